// *** atb_pkg.sv ***
// package of constants for the advanced timer time base
// assumes one 10 MHz clock and software controls presented as plain ports
package atb_pkg;
   localparam int ATB_CNT_W = 16;
   localparam int ATB_RCR_W = 16;
   localparam logic [15:0] ATB_CNT_RST = 16'h0000;
   localparam logic [15:0] ATB_ARR_RST = 16'hFFFF;
   localparam logic [15:0] ATB_PSC_RST = 16'h0000;
   localparam logic [15:0] ATB_RCR_RST = 16'h0000;
   localparam logic [1:0] ATB_CMS_EDGE = 2'h0;
   localparam logic [1:0] ATB_CMS_DOWN_FLAGS = 2'h1;
   localparam logic [1:0] ATB_CMS_UP_FLAGS = 2'h2;
   localparam logic [1:0] ATB_CMS_BOTH_FLAGS = 2'h3;
   localparam logic [3:0] ATB_SMS_INTERNAL = 4'h0;
   typedef enum logic [1:0] {
      ATB_MODE_UP,
      ATB_MODE_DOWN,
      ATB_MODE_CENTER
   } atb_mode_t;
endpackage

// *** atb_prescaler.sv ***
// prescaler counter producing the counter tick
// assumes enable is a one-cycle qualifier of the prescaler input clock
`timescale 1ns/100ps
module atb_prescaler #(
   parameter int W = 16
) (
   input wire logic I_CLOCK, // system clock
   input wire logic I_RST, // async reset, active high
   input wire logic i_enable, // prescaler input clock enable
   input wire logic i_restart, // restart division from 0
   input wire logic [W-1:0] i_div, // active division value
   output logic o_tick // counter tick pulse
);
   logic [W-1:0] div_cnt_reg;

   assign o_tick = i_enable && !i_restart && (div_cnt_reg >= i_div);

   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         div_cnt_reg <= '0;
      end else if (i_restart || o_tick) begin
         div_cnt_reg <= '0;
      end else if (i_enable) begin
         div_cnt_reg <= div_cnt_reg + W'(1);
      end
   end
endmodule

// *** atb_time_base.sv ***
// time base of the advanced timer: prescaler, counter, reload and repetition logic
// assumes software writes arrive as one-cycle strobes with data on plain ports
`timescale 1ns/100ps
module atb_time_base #(
   parameter int CW = atb_pkg::ATB_CNT_W,
   parameter int RW = atb_pkg::ATB_RCR_W
) (
   input wire logic I_CLOCK, // system clock 10 MHz
   input wire logic I_RST, // async reset, active high
   input wire logic I_COUNT_RUN, // count_run control bit
   input wire logic I_RELOAD_PRELOAD_EN, // reload_preload_en control bit
   input wire logic I_UPDATE_DISABLE, // update_disable control bit
   input wire logic I_UPDATE_SOURCE_SEL, // update_source_sel control bit
   input wire logic [1:0] I_CENTER_ALIGN_SEL, // center_align_sel field
   input wire logic I_DIR_DOWN, // software direction, 1 = down
   input wire logic [3:0] I_SLAVE_MODE_SEL, // slave_mode_sel field
   input wire logic I_SLAVE_CLK_EN, // prescaler input enable from slave logic
   input wire logic I_FORCE_UPDATE, // software writes 1 to force_update
   input wire logic I_SLAVE_FORCE_UPDATE, // slave controller sets force_update
   input wire logic I_FLAG_CLR, // clears update_flag
   input wire logic I_CNT_WR, // counter_value write strobe
   input wire logic [CW-1:0] I_CNT_WDATA, // counter_value write data
   input wire logic I_ARR_WR, // reload_value write strobe
   input wire logic [CW-1:0] I_ARR_WDATA, // reload_value write data
   input wire logic I_PSC_WR, // prescale_value write strobe
   input wire logic [CW-1:0] I_PSC_WDATA, // prescale_value write data
   input wire logic I_RCR_WR, // repetition_count write strobe
   input wire logic [RW-1:0] I_RCR_WDATA, // repetition_count write data
   output logic [CW-1:0] O_COUNTER_VALUE, // counter_value readback
   output logic [CW-1:0] O_RELOAD_VALUE, // reload_value readback
   output logic [CW-1:0] O_PRESCALE_VALUE, // prescale_value readback
   output logic [RW-1:0] O_REPETITION_COUNT, // repetition_count readback
   output logic [RW-1:0] O_REPEAT_LEFT, // wraps left before next update
   output logic O_FORCE_UPDATE, // force_update readback
   output logic O_UPDATE_FLAG, // update_flag status
   output logic O_UPDATE_EVENT, // update_event pulse
   output logic O_OVERFLOW, // counter overflow pulse
   output logic O_UNDERFLOW, // counter underflow pulse
   output logic O_COUNTER_TICK, // counter_tick pulse
   output logic O_DIR_DOWN, // current direction, 1 = down
   output logic O_COMPARE_FLAG_EN // compare flags allowed in this direction
);
   import atb_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic [CW-1:0] arr_pre_reg;
   logic [CW-1:0] arr_shadow_reg;
   logic [CW-1:0] psc_pre_reg;
   logic [CW-1:0] psc_shadow_reg;
   logic [RW-1:0] rcr_reg;
   logic [RW-1:0] rep_reg;
   logic [RW-1:0] rep_next;
   logic run_reg;
   logic force_reg;
   logic dir_reg;
   logic dir_next;
   logic flag_reg;
   logic ovf_reg;
   logic unf_reg;
   logic uev_reg;
   logic wrap_ovf;
   logic wrap_unf;
   logic wrap_uev;
   logic update_event;
   logic set_flag;
   logic tick;
   logic psc_in;
   logic [CW-1:0] arr_act;
   atb_mode_t mode;

   // ************************************************************
   // mode and clock selection
   // ************************************************************
   always_comb begin
      if (I_CENTER_ALIGN_SEL != ATB_CMS_EDGE) begin
         mode = ATB_MODE_CENTER;
      end else if (I_DIR_DOWN) begin
         mode = ATB_MODE_DOWN;
      end else begin
         mode = ATB_MODE_UP;
      end
   end

   // internal clock feeds the prescaler every cycle while run_reg is set when slave mode is off
   assign psc_in = run_reg && ((I_SLAVE_MODE_SEL == ATB_SMS_INTERNAL) || I_SLAVE_CLK_EN);

   // reload takes effect at once when preload is off
   assign arr_act = I_RELOAD_PRELOAD_EN ? arr_shadow_reg : arr_pre_reg;

   atb_prescaler #(
      .W(CW)
   ) u_prescaler (
      .I_CLOCK(I_CLOCK),
      .I_RST(I_RST),
      .i_enable(psc_in),
      .i_restart(force_reg),
      .i_div(psc_shadow_reg),
      .o_tick(tick)
   );

   // ************************************************************
   // counter next value and wrap detection
   // ************************************************************
   always_comb begin
      cnt_next = cnt_reg;
      dir_next = dir_reg;
      wrap_ovf = 1'b0;
      wrap_unf = 1'b0;
      if (mode != ATB_MODE_CENTER) begin
         dir_next = I_DIR_DOWN;
      end
      if (tick && !force_reg && !I_CNT_WR) begin
         case (mode)
            ATB_MODE_UP: begin
               if (cnt_reg >= arr_act) begin
                  cnt_next = '0;
                  wrap_ovf = 1'b1;
               end else begin
                  cnt_next = cnt_reg + CW'(1);
               end
            end
            ATB_MODE_DOWN: begin
               if (cnt_reg == '0) begin
                  cnt_next = arr_act;
                  wrap_unf = 1'b1;
               end else begin
                  cnt_next = cnt_reg - CW'(1);
               end
            end
            default: begin
               if (arr_act == '0) begin
                  cnt_next = '0;
               end else if (!dir_reg) begin
                  if (cnt_reg >= arr_act - CW'(1)) begin
                     cnt_next = arr_act;
                     dir_next = 1'b1;
                     wrap_ovf = 1'b1;
                  end else begin
                     cnt_next = cnt_reg + CW'(1);
                  end
               end else begin
                  if (cnt_reg <= CW'(1)) begin
                     cnt_next = '0;
                     dir_next = 1'b0;
                     wrap_unf = 1'b1;
                  end else begin
                     cnt_next = cnt_reg - CW'(1);
                  end
               end
            end
         endcase
      end
   end

   // ************************************************************
   // repetition and update event
   // ************************************************************
   always_comb begin
      rep_next = rep_reg;
      wrap_uev = 1'b0;
      // wraps keep using up repetitions while updates are disabled
      if (wrap_ovf || wrap_unf) begin
         if (rep_reg != '0) begin
            rep_next = rep_reg - RW'(1);
         end else if (!I_UPDATE_DISABLE) begin
            wrap_uev = 1'b1;
         end
      end
      if (force_reg || wrap_uev) begin
         rep_next = rcr_reg;
      end
   end

   assign update_event = force_reg || wrap_uev;
   assign set_flag = wrap_uev || (force_reg && !I_UPDATE_SOURCE_SEL);

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         run_reg <= 1'b0;
      end else begin
         run_reg <= I_COUNT_RUN;
      end
   end

   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         force_reg <= 1'b0;
      end else begin
         force_reg <= I_FORCE_UPDATE || I_SLAVE_FORCE_UPDATE;
      end
   end

   // a forced update reinitialises the count ahead of any write or tick
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         cnt_reg <= ATB_CNT_RST;
         dir_reg <= 1'b0;
      end else if (force_reg) begin
         cnt_reg <= (mode == ATB_MODE_DOWN) ? (I_RELOAD_PRELOAD_EN ? arr_pre_reg : arr_act)
                                            : '0;
         dir_reg <= (mode == ATB_MODE_CENTER) ? 1'b0 : I_DIR_DOWN;
      end else if (I_CNT_WR) begin
         cnt_reg <= I_CNT_WDATA;
         dir_reg <= dir_next;
      end else if (run_reg) begin
         cnt_reg <= cnt_next;
         dir_reg <= dir_next;
      end else begin
         dir_reg <= dir_next;
      end
   end

   // preload registers accept software writes at any time
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         arr_pre_reg <= ATB_ARR_RST;
         psc_pre_reg <= ATB_PSC_RST;
         rcr_reg <= RW'(ATB_RCR_RST);
      end else begin
         if (I_ARR_WR) begin
            arr_pre_reg <= I_ARR_WDATA;
         end
         if (I_PSC_WR) begin
            psc_pre_reg <= I_PSC_WDATA;
         end
         if (I_RCR_WR) begin
            rcr_reg <= I_RCR_WDATA;
         end
      end
   end

   // shadows follow their preloads only on an update event
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         arr_shadow_reg <= ATB_ARR_RST;
         psc_shadow_reg <= ATB_PSC_RST;
         rep_reg <= RW'(ATB_RCR_RST);
      end else begin
         rep_reg <= rep_next;
         if (update_event) begin
            arr_shadow_reg <= arr_pre_reg;
            psc_shadow_reg <= psc_pre_reg;
         end
      end
   end

   // hardware set wins over a clear in the same cycle
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         flag_reg <= 1'b0;
      end else if (set_flag) begin
         flag_reg <= 1'b1;
      end else if (I_FLAG_CLR) begin
         flag_reg <= 1'b0;
      end
   end

   // event and wrap pulses stand one cycle behind the edge that makes them
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         uev_reg <= 1'b0;
         ovf_reg <= 1'b0;
         unf_reg <= 1'b0;
      end else begin
         uev_reg <= update_event;
         ovf_reg <= wrap_ovf && run_reg;
         unf_reg <= wrap_unf && run_reg;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   // edge mode lets compare flags through in both directions
   always_comb begin
      case (I_CENTER_ALIGN_SEL)
         ATB_CMS_DOWN_FLAGS: O_COMPARE_FLAG_EN = dir_reg;
         ATB_CMS_UP_FLAGS: O_COMPARE_FLAG_EN = !dir_reg;
         ATB_CMS_BOTH_FLAGS: O_COMPARE_FLAG_EN = 1'b1;
         default: O_COMPARE_FLAG_EN = 1'b1;
      endcase
   end

   assign O_COUNTER_VALUE = cnt_reg;
   assign O_RELOAD_VALUE = arr_pre_reg;
   assign O_PRESCALE_VALUE = psc_pre_reg;
   assign O_REPETITION_COUNT = rcr_reg;
   assign O_REPEAT_LEFT = rep_reg;
   assign O_FORCE_UPDATE = force_reg;
   assign O_UPDATE_FLAG = flag_reg;
   assign O_UPDATE_EVENT = uev_reg;
   assign O_OVERFLOW = ovf_reg;
   assign O_UNDERFLOW = unf_reg;
   assign O_COUNTER_TICK = tick && run_reg;
   assign O_DIR_DOWN = dir_reg;
endmodule

// *** atb_time_base_sva.sv ***
// checker of the time base port behaviour
// assumes one clock domain and a bind onto atb_time_base
`timescale 1ns/100ps
module atb_time_base_sva #(
   parameter int CW = 16,
   parameter int RW = 16
) (
   input wire logic I_CLOCK, // clock
   input wire logic I_RST, // reset
   input wire logic I_COUNT_RUN, // control
   input wire logic I_RELOAD_PRELOAD_EN, // control
   input wire logic [CW-1:0] O_RELOAD_VALUE, // reload preload
   input wire logic I_UPDATE_DISABLE, // control
   input wire logic I_UPDATE_SOURCE_SEL, // control
   input wire logic [1:0] I_CENTER_ALIGN_SEL, // control
   input wire logic I_DIR_DOWN, // control
   input wire logic I_FORCE_UPDATE, // request
   input wire logic I_CNT_WR, // request
   input wire logic [CW-1:0] O_COUNTER_VALUE, // counter
   input wire logic [RW-1:0] O_REPEAT_LEFT, // wraps left
   input wire logic O_FORCE_UPDATE, // force bit
   input wire logic O_UPDATE_FLAG, // flag
   input wire logic O_UPDATE_EVENT, // event
   input wire logic O_OVERFLOW, // wrap up
   input wire logic O_UNDERFLOW, // wrap down
   input wire logic O_COUNTER_TICK, // tick
   input wire logic O_DIR_DOWN, // direction
   input wire logic O_COMPARE_FLAG_EN // compare enable
);
   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (I_RST);
   // ****************
   // assertions
   // ****************
   force_pulse_a: assert property (I_FORCE_UPDATE |=> O_FORCE_UPDATE ##1 !O_FORCE_UPDATE)
      else $error("force bit is not a one-cycle pulse");
   force_update_a: assert property (O_FORCE_UPDATE |=> O_UPDATE_EVENT)
      else $error("forced update gave no update event");
   force_flag_a: assert property (O_FORCE_UPDATE && !I_UPDATE_SOURCE_SEL |=> O_UPDATE_FLAG)
      else $error("forced update did not set the flag");
   quiet_flag_a: assert property (O_FORCE_UPDATE && I_UPDATE_SOURCE_SEL && !O_UPDATE_FLAG
      && !O_COUNTER_TICK |=> !O_UPDATE_FLAG) else $error("quiet forced update set the flag");
   disable_block_a: assert property ($past(I_UPDATE_DISABLE) && !$past(O_FORCE_UPDATE)
      |-> !O_UPDATE_EVENT) else $error("update event while updates disabled");
   repeat_gate_a: assert property ((O_OVERFLOW || O_UNDERFLOW) && $past(O_REPEAT_LEFT) != 0
      && !$past(O_FORCE_UPDATE) |-> !O_UPDATE_EVENT) else $error("update before repeats ran out");
   idle_hold_a: assert property (!O_COUNTER_TICK && !I_CNT_WR && !O_FORCE_UPDATE
      |=> $stable(O_COUNTER_VALUE)) else $error("counter moved without a tick");
   up_wrap_a: assert property (O_OVERFLOW && I_CENTER_ALIGN_SEL == 2'h0 && !I_DIR_DOWN
      |-> O_COUNTER_VALUE == '0) else $error("up count did not restart at zero");
   cmp_mode_a: assert property (I_CENTER_ALIGN_SEL == 2'h1 |-> O_COMPARE_FLAG_EN == O_DIR_DOWN)
      else $error("compare enable wrong for center mode one");
   run_gate_a: assert property (!$past(I_COUNT_RUN) |-> !O_COUNTER_TICK)
      else $error("counter ticked while stopped");
   down_wrap_a: assert property (O_UNDERFLOW && I_CENTER_ALIGN_SEL == 2'h0
      && I_DIR_DOWN && !I_RELOAD_PRELOAD_EN |-> O_COUNTER_VALUE == $past(O_RELOAD_VALUE))
      else $error("down count did not restart at the reload value");
   center_top_a: assert property (O_OVERFLOW && I_CENTER_ALIGN_SEL != 2'h0
      && !I_RELOAD_PRELOAD_EN |-> O_DIR_DOWN && O_COUNTER_VALUE == $past(O_RELOAD_VALUE))
      else $error("center count did not turn at the reload value");
   center_floor_a: assert property (O_UNDERFLOW && I_CENTER_ALIGN_SEL != 2'h0
      |-> !O_DIR_DOWN && O_COUNTER_VALUE == '0) else $error("center count did not turn up at zero");
   cover property (O_UPDATE_EVENT && O_UNDERFLOW);
   cover property (O_FORCE_UPDATE && I_UPDATE_SOURCE_SEL);
   cover property (O_OVERFLOW && I_CENTER_ALIGN_SEL == 2'h3);
endmodule
bind atb_time_base atb_time_base_sva #(.CW(CW), .RW(RW)) atb_time_base_sva_i (.*);

// *** atb_time_base_tb.sv ***
// self-checking testbench of the advanced timer time base
// assumes the design and its bound checker are compiled before it
`timescale 1ns/100ps
module atb_time_base_tb;
   import atb_pkg::*;
   logic I_CLOCK = '0, I_RST = '1, I_COUNT_RUN = '0, I_RELOAD_PRELOAD_EN = '0, I_DIR_DOWN = '0;
   logic I_UPDATE_DISABLE = '0, I_UPDATE_SOURCE_SEL = '0, I_SLAVE_CLK_EN = '0;
   logic [1:0] I_CENTER_ALIGN_SEL = ATB_CMS_EDGE;
   logic [3:0] I_SLAVE_MODE_SEL = ATB_SMS_INTERNAL;
   wire I_CNT_WR, I_ARR_WR, I_PSC_WR, I_RCR_WR, I_FORCE_UPDATE, I_SLAVE_FORCE_UPDATE, I_FLAG_CLR;
   wire [15:0] I_CNT_WDATA, I_ARR_WDATA, I_PSC_WDATA, I_RCR_WDATA;
   logic [15:0] O_COUNTER_VALUE, O_RELOAD_VALUE, O_PRESCALE_VALUE, O_REPETITION_COUNT;
   logic [15:0] O_REPEAT_LEFT;
   logic O_FORCE_UPDATE, O_UPDATE_FLAG, O_UPDATE_EVENT, O_OVERFLOW, O_UNDERFLOW;
   logic O_COUNTER_TICK, O_DIR_DOWN, O_COMPARE_FLAG_EN;
   logic [6:0] strb = '0;
   logic [15:0] wd = '0;
   logic [31:0] lfsr_q = 32'h0001_19FA;
   int n_mismatch = 0;
   int checks = 0;
   assign {I_CNT_WR, I_ARR_WR, I_PSC_WR, I_RCR_WR, I_FORCE_UPDATE, I_SLAVE_FORCE_UPDATE,
      I_FLAG_CLR} = strb;
   assign {I_CNT_WDATA, I_ARR_WDATA, I_PSC_WDATA, I_RCR_WDATA} = {4{wd}};
   atb_time_base atb_time_base_i (.*);
   always #50 I_CLOCK = ~I_CLOCK;
   function automatic logic [15:0] rnd(input logic [15:0] lo, input logic [15:0] span);
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      return lo + lfsr_q[15:0] % span;
   endfunction
   // cycles between update events for one setting
   function automatic int per(input logic [1:0] center_align_sel, input logic [15:0] p, a, r);
      return (r + 1) * (p + 1) * (center_align_sel == ATB_CMS_EDGE ? a + 1 : a);
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge I_CLOCK);
      #1;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // k: 0 counter, 1 reload, 2 prescale, 3 repetition, 4 force, 5 slave force, 6 flag clear
   task automatic pulse(input int k, input logic [15:0] d);
      wd = d;
      strb = 7'h40 >> k;
      cyc(1);
      strb = 7'h00;
      cyc(1);
   endtask
   task automatic wait_ev(input int lim, output int n);
      n = 0;
      do begin
         cyc(1);
         n++;
      end while (O_UPDATE_EVENT !== 1'b1 && n < lim);
   endtask
   // ****************
   // scenarios
   // ****************
   task automatic run(input logic [1:0] center_align_sel, input logic dn, input logic ape);
      logic [15:0] p, a, r, p2, a2;
      int n;
      p = rnd(16'h0000, 16'h0004);
      a = rnd(16'h0002, 16'h0004);
      r = rnd(16'h0000, 16'h0004);
      p2 = rnd(16'h0000, 16'h0004);
      a2 = rnd(16'h0006, 16'h0004);
      {I_CENTER_ALIGN_SEL, I_DIR_DOWN, I_RELOAD_PRELOAD_EN} = {center_align_sel, dn, ape};
      pulse(2, p);
      pulse(1, a);
      pulse(3, r);
      pulse(4, 16'h0000);
      check(O_PRESCALE_VALUE, p);
      check(O_REPEAT_LEFT, r);
      check(O_REPETITION_COUNT, r);
      I_COUNT_RUN = 1'b1;
      wait_ev(4000, n);
      wait_ev(4000, n);
      check(n, per(center_align_sel, p, a, r));
      if (center_align_sel == ATB_CMS_EDGE && !dn) begin
         pulse(1, a2);
         pulse(2, p2);
         wait_ev(4000, n);
         check(n + 4, ape ? per(center_align_sel, p, a, r) : per(center_align_sel, p, a2, r));
         wait_ev(4000, n);
         check(n, per(center_align_sel, p2, a2, r));
      end
      I_UPDATE_DISABLE = 1'b1;
      wait_ev(600, n);
      check(n, 600);
      {I_UPDATE_DISABLE, I_COUNT_RUN} = 2'b00;
      cyc(2);
   endtask
   initial begin
      logic [15:0] d;
      cyc(8);
      I_RST = '0;
      check(O_RELOAD_VALUE, ATB_ARR_RST);
      check(O_COUNTER_VALUE, ATB_CNT_RST);
      for (int i = 0; i < 6; i++) begin
         run(i < 3 ? ATB_CMS_EDGE : 2'(i - 2), i == 2, i == 1);
      end
      d = rnd(16'h0000, 16'h0064);
      pulse(0, d);
      check(O_COUNTER_VALUE, d);
      cyc(5);
      check(O_COUNTER_VALUE, d);
      {I_SLAVE_MODE_SEL, I_COUNT_RUN} = {4'h7, 1'b1};
      cyc(5);
      check(O_COUNTER_VALUE, d);
      {I_SLAVE_MODE_SEL, I_COUNT_RUN} = {ATB_SMS_INTERNAL, 1'b0};
      cyc(2);
      pulse(6, 16'h0000);
      check(O_UPDATE_FLAG, 1'b0);
      I_UPDATE_SOURCE_SEL = 1'b1;
      pulse(4, 16'h0000);
      check(O_UPDATE_FLAG, 1'b0);
      check(O_FORCE_UPDATE, 1'b0);
      I_UPDATE_SOURCE_SEL = 1'b0;
      pulse(5, 16'h0000);
      check(O_UPDATE_FLAG, 1'b1);
      end_sim();
   end
   // cuts a hang short well past the longest expected run
   initial begin
      cyc(50000);
      n_mismatch++;
      end_sim();
   end
endmodule
